// >>> dv/ddp_assertions.sv
// Purpose: port checks for the memory pin datapath
// Assumes: settle counts of six cycles
// Notes: bound from the bench top
`timescale 1ns/1ps
module ddp_assertions import ddp_pkg::*; #(
    parameter int DW = 8
) (
    // clocks and reset
    input wire logic clk,
    input wire logic wr_clk,
    input wire logic rst_n,
    // watched signals
    input wire ddp_mode_t mode,
    input wire logic postamble_arm,
    input wire logic wr_mask,
    input wire logic strobe_oe,
    input wire logic [DW-1:0] dq_oe,
    input wire logic mask_o,
    input wire logic capture_enable_n
);
    // ****************
    // checks
    // ****************
    a_read_dq_off: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == DDP_READ)[*6] |-> dq_oe == '0) else $error("dq driven in read");
    a_read_dqs_off: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == DDP_READ)[*6] |-> !strobe_oe) else $error("strobe driven in read");
    a_idle_off: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == DDP_IDLE)[*6] |-> dq_oe == '0 && !strobe_oe) else $error("driven in idle");
    a_write_on: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == DDP_WRITE)[*6] |-> dq_oe == '1) else $error("dq not driven");
    a_mask_low: assert property (@(posedge wr_clk) disable iff (!rst_n)
        (mode == DDP_WRITE && !wr_mask)[*6] |-> !mask_o) else $error("mask high");
    a_mask_high: assert property (@(posedge wr_clk) disable iff (!rst_n)
        (mode == DDP_WRITE && wr_mask)[*6] |-> mask_o) else $error("mask low");
    a_arm_block: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(capture_enable_n) |-> postamble_arm) else $error("capture stop unarmed");
    a_rearm_on: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(capture_enable_n) |-> !$past(postamble_arm)) else $error("capture while armed");
endmodule : ddp_assertions

// >>> dv/ddp_datapath_bench.sv
// Purpose: bench for the memory pin datapath
// Assumes: resync clock tied to system clock
// Notes: memory model drives strobe and data
`timescale 1ns/1ps
`include "ddp_params.svh"
module ddp_datapath_bench;
    import ddp_pkg::*;
    logic clk = 0, wr_clk = 0, tap_clk = 0, rst_n = 0, postamble_arm = 0, wr_mask = 1;
    logic strobe_o, strobe_oe, mask_o, capture_enable_n, mem_dqs;
    logic [7:0] dq_o, dq_oe, rd_hi, rd_lo, mem_dq, wr_hi = 0, wr_lo = 0;
    ddp_mode_t mode = DDP_IDLE;
    logic [`DDP_DLY_W-1:0] delay_set = `DDP_DLY_RST;
    int miscompares = 0, num_checks = 0, cycles = 0;
    wire strobe_w = strobe_oe ? strobe_o : mem_dqs;
    wire [7:0] dq_w = (dq_oe & dq_o) | (~dq_oe & mem_dq);
    initial forever #25 clk = ~clk;
    initial begin
        #12.5;
        forever #25 wr_clk = ~wr_clk;
    end
    initial forever #1.5 tap_clk = ~tap_clk;
    ddp_datapath ddp_datapath_i (.clk, .wr_clk, .resync_clk(clk), .tap_clk, .rst_n,
        .strobe_i(strobe_w), .strobe_o, .strobe_oe, .dq_i(dq_w), .dq_o, .dq_oe, .mask_o,
        .mode, .postamble_arm, .delay_set, .wr_hi, .wr_lo, .wr_mask,
        .rd_hi, .rd_lo, .capture_enable_n);
    ddp_mem_model mem_i (.strobe(mem_dqs), .dq(mem_dq));
    // ****************
    // helpers
    // ****************
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task test_done;
        if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    always @(posedge clk) if (++cycles > 3000) begin
        miscompares++;
        test_done();
    end
    // ****************
    // scenarios
    // ****************
    task t_write(input logic m, input logic [7:0] a);
        logic was_idle;
        @(negedge clk);
        was_idle = (mode == DDP_IDLE);
        mode = DDP_WRITE;
        wr_hi = a;
        wr_lo = ~a;
        wr_mask = m;
        if (was_idle) begin
            @(posedge clk);
            #6 check({6'h00, strobe_oe, strobe_o}, 8'h02);
        end
        cyc(8);
        check(dq_oe, 8'hFF);
        check({6'h00, strobe_oe, strobe_o}, 8'h02);
        check({7'h00, mask_o}, {7'h00, m});
        @(posedge wr_clk);
        #6 check(dq_o, a);
        check({7'h00, strobe_o}, 8'h01);
        @(negedge wr_clk);
        #6 check(dq_o, ~a);
        check({7'h00, strobe_o}, 8'h00);
    endtask : t_write
    task t_read(input logic [31:0] w, input logic [`DDP_DLY_W-1:0] d);
        logic was_wr;
        @(negedge clk);
        was_wr = (mode == DDP_WRITE);
        mode = DDP_READ;
        delay_set = d;
        if (was_wr) begin
            @(posedge clk);
            #6 check({6'h00, strobe_oe, strobe_o}, 8'h02);
        end
        cyc(8);
        check(dq_oe, 8'h00);
        check({7'h00, strobe_oe}, 8'h00);
        #7 mem_i.burst(w);
        cyc(4);
        check(rd_hi, w[23:16]);
        check(rd_lo, w[31:24]);
    endtask : t_read
    task t_postamble;
        postamble_arm = 1'b1;
        cyc(6);
        check({7'h00, capture_enable_n}, 8'h00);
        mem_i.glitch();
        cyc(6);
        check({7'h00, capture_enable_n}, 8'h01);
        postamble_arm = 1'b0;
        cyc(12);
        check({7'h00, capture_enable_n}, 8'h00);
    endtask : t_postamble
    initial begin
        cyc(10);
        check(dq_oe, 8'h00);
        check({6'h00, mask_o, capture_enable_n}, 8'h03);
        rst_n = 1'b1;
        cyc(8);
        t_write(1'b0, 8'h3C);
        t_write(1'b1, 8'hA9);
        t_read(32'h87654321, `DDP_DLY_RST);
        t_postamble();
        t_read(32'h0FF01EE1, 4'h2);
        test_done();
    end
endmodule : ddp_datapath_bench
bind ddp_datapath ddp_assertions #(.DW(DW)) ddp_assertions_i (.clk, .wr_clk, .rst_n, .mode,
    .postamble_arm, .wr_mask, .strobe_oe, .dq_oe, .mask_o, .capture_enable_n);

// >>> dv/ddp_mem_model.sv
// Purpose: memory side strobe and data driver
// Assumes: strobe period 48 ns
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module ddp_mem_model (
    // memory pins
    output logic strobe,
    output logic [7:0] dq
);
    initial begin
        strobe = 1'b1;
        dq = 8'hA5;
    end
    // four words, edge aligned
    task burst(input logic [31:0] w);
        strobe = 1'b0;
        #48;
        for (int i = 0; i < 4; i++) begin
            strobe = ~strobe;
            dq = w[8*i +: 8];
            #24;
        end
        #96;
        strobe = 1'b1;
        dq = ~dq;
    endtask : burst
    // noise on a floating strobe
    task glitch;
        strobe = 1'b0;
        #10;
        strobe = 1'b1;
    endtask : glitch
endmodule : ddp_mem_model

// >>> rtl/ddp_datapath.sv
// Purpose: double-rate memory pin datapath, read capture and write drive
// Assumes: system clock 20 MHz, strobe as link clock
// Notes: delayed strobe clocks capture; write mux on write clock
//
// Notes on behaviour
// - strobe is delayed so its edges centre in the data window
// - delayed strobe clocks capture registers, used only during reads
// - delay setting is tunable to match strobe and data routing
// - driver holds strobe low for preamble and postamble around tri-state
// - postamble flop on shifted strobe, data zero, async preset
// - preset released on a system clock edge once the synced arm is seen in read mode
// - after postamble edge an active-low enable stops capture
// - five registers per pin, two capture on rising and falling edges
// - third register realigns second edge data before resync
// - two resync registers retime high and low streams
// - shifted strobe inverted before clocking input registers
// - inversion keeps final word on last falling edge
// - first edge and aligning register outputs map swapped to high/low
// - two output registers multiplexed by clock at twice rate
// - clock high carries first register, low carries second
// - tri-state enable from write logic controls pin drive
// - write data and mask launched from lagging write clock
// - mask low writes byte, high makes memory ignore it
`timescale 1ns/1ps
`include "ddp_params.svh"
module ddp_datapath #(
    parameter int DW = `DDP_DATA_W
) (
    // clocks and reset
    input wire logic clk,
    input wire logic wr_clk,
    input wire logic resync_clk,
    input wire logic tap_clk,
    input wire logic rst_n,
    // strobe pin
    input wire logic strobe_i,
    output logic strobe_o,
    output logic strobe_oe,
    // data pins
    input wire logic [DW-1:0] dq_i,
    output logic [DW-1:0] dq_o,
    output logic [DW-1:0] dq_oe,
    output logic mask_o,
    // user control
    input wire ddp_pkg::ddp_mode_t mode,
    input wire logic postamble_arm,
    input wire logic [`DDP_DLY_W-1:0] delay_set,
    // user write data
    input wire logic [DW-1:0] wr_hi,
    input wire logic [DW-1:0] wr_lo,
    input wire logic wr_mask,
    // user read data
    output logic [DW-1:0] rd_hi,
    output logic [DW-1:0] rd_lo,
    output logic capture_enable_n
);
    import ddp_pkg::*;
    // ****************************************
    // checks and helpers
    // ****************************************
    if (DW < 1) begin : g_bad_dw
        $error("data width must be at least one");
    end
    function automatic logic is_read(input ddp_mode_t m);
        return m == DDP_READ;
    endfunction : is_read
    function automatic logic is_write(input ddp_mode_t m);
        return m == DDP_WRITE;
    endfunction : is_write
    // ****************************************
    // strobe delay and inversion
    // ****************************************
    logic strobe_dly;
    logic strobe_inv;
    ddp_delay #(.TAPS(`DDP_DLY_TAPS)) u_dly (
        .tap_clk(tap_clk),
        .rst_n(rst_n),
        .strobe_in(strobe_i),
        .tap_sel(delay_set),
        .strobe_out(strobe_dly)
    );
    // capture clock only during reads
    logic rd_mode;
    assign rd_mode = is_read(mode);
    assign strobe_inv = ~(strobe_dly & rd_mode);
    // ****************************************
    // postamble flop
    // ****************************************
    logic pa_arm_sync;
    ddp_sync #(.W(1)) u_arm (
        .clk(clk),
        .rst_n(rst_n),
        .d(postamble_arm),
        .q(pa_arm_sync)
    );
    // system clock state: preset control and strobe drive
    typedef struct packed {
        logic preset;
        logic oe;
        logic toggle;
    } ddp_sys_st_t;
    ddp_sys_st_t ss_reg;
    ddp_sys_st_t ss_next;
    always_comb begin
        ss_next.preset = ~(is_read(mode) & pa_arm_sync);
        ss_next.oe = is_write(mode) | ss_reg.toggle;
        ss_next.toggle = is_write(mode) & ss_reg.oe;
        if (!rst_n) begin
            ss_next = '0;
            ss_next.preset = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        ss_reg <= ss_next;
    end
    logic pa_q;
    // zero sampled on strobe fall, preset holds it high
    always_ff @(posedge strobe_inv or posedge ss_reg.preset) begin
        if (ss_reg.preset) begin
            pa_q <= 1'b1;
        end else begin
            pa_q <= 1'b0;
        end
    end
    logic cap_en;
    assign cap_en = pa_q;
    // enable status crosses into the resync domain
    logic cap_en_rsy;
    ddp_sync #(.W(1)) u_en (
        .clk(resync_clk),
        .rst_n(rst_n),
        .d(cap_en),
        .q(cap_en_rsy)
    );
    // ****************************************
    // capture registers on inverted strobe
    // ****************************************
    typedef struct packed {
        logic [DW-1:0] a;
        logic [DW-1:0] c;
    } ddp_rise_st_t;
    typedef struct packed {
        logic [DW-1:0] b;
    } ddp_fall_st_t;
    ddp_rise_st_t rs_reg;
    ddp_rise_st_t rs_next;
    ddp_fall_st_t fs_reg;
    ddp_fall_st_t fs_next;
    always_comb begin
        rs_next = rs_reg;
        if (cap_en) begin
            rs_next.a = dq_i;
            rs_next.c = fs_reg.b;
        end
    end
    always_ff @(posedge strobe_inv) begin
        rs_reg <= rs_next;
    end
    always_comb begin
        fs_next = fs_reg;
        if (cap_en) begin
            fs_next.b = dq_i;
        end
    end
    always_ff @(negedge strobe_inv) begin
        fs_reg <= fs_next;
    end
    // ****************************************
    // resync stage
    // ****************************************
    typedef struct packed {
        logic [DW-1:0] h;
        logic [DW-1:0] l;
        logic en_n;
    } ddp_rsy_st_t;
    ddp_rsy_st_t ry_reg;
    ddp_rsy_st_t ry_next;
    always_comb begin
        ry_next.h = rs_reg.c;
        ry_next.l = rs_reg.a;
        ry_next.en_n = ~cap_en_rsy;
        if (!rst_n) begin
            ry_next = '0;
            ry_next.en_n = 1'b1;
        end
    end
    always_ff @(posedge resync_clk) begin
        ry_reg <= ry_next;
    end
    assign rd_hi = ry_reg.h;
    assign rd_lo = ry_reg.l;
    assign capture_enable_n = ry_reg.en_n;
    // ****************************************
    // write registers
    // ****************************************
    typedef struct packed {
        logic [DW-1:0] a;
        logic [DW-1:0] b;
        logic m;
        logic oe;
    } ddp_wr_st_t;
    ddp_wr_st_t wd_reg;
    ddp_wr_st_t wd_next;
    always_comb begin
        wd_next.a = wr_hi;
        wd_next.b = wr_lo;
        wd_next.m = wr_mask;
        wd_next.oe = is_write(mode);
        if (!rst_n) begin
            wd_next = '0;
            wd_next.m = 1'b1;
        end
    end
    always_ff @(posedge wr_clk) begin
        wd_reg <= wd_next;
    end
    // strobe driven from system clock, low in pre/postamble
    assign strobe_o = ss_reg.toggle & clk;
    assign strobe_oe = ss_reg.oe;
    assign dq_o = wr_clk ? wd_reg.a : wd_reg.b;
    assign dq_oe = {DW{wd_reg.oe}};
    assign mask_o = wd_reg.m;
endmodule : ddp_datapath

// >>> rtl/ddp_delay.sv
// Purpose: tunable strobe delay tap line
// Assumes: fast tap clock, setting static during reads
// Notes: taps sample strobe on tap clock
`timescale 1ns/1ps
`include "ddp_params.svh"
module ddp_delay #(
    parameter int TAPS = `DDP_DLY_TAPS
) (
    // tap clock
    input wire logic tap_clk,
    input wire logic rst_n,
    // strobe
    input wire logic strobe_in,
    input wire logic [`DDP_DLY_W-1:0] tap_sel,
    output logic strobe_out
);
    typedef struct packed {
        logic [TAPS-1:0] line;
    } ddp_delay_st_t;
    ddp_delay_st_t st_reg;
    ddp_delay_st_t st_next;
    if (TAPS < 2 || TAPS > (1 << `DDP_DLY_W)) begin : g_bad_taps
        $error("tap count out of range");
    end
    always_comb begin
        st_next.line = {st_reg.line[TAPS-2:0], strobe_in};
        if (!rst_n) begin
            st_next = '0;
        end
    end
    always_ff @(posedge tap_clk) begin
        st_reg <= st_next;
    end
    assign strobe_out = st_reg.line[tap_sel];
endmodule : ddp_delay

// >>> rtl/ddp_params.svh
// Purpose: constants for the memory pin datapath
// Assumes: 20 MHz system clock
// Notes: definitions only
`ifndef DDP_PARAMS_SVH
`define DDP_PARAMS_SVH
`define DDP_DATA_W 8
`define DDP_DLY_W 4
`define DDP_DLY_RST 4'h4
`define DDP_DLY_TAPS 16
`define DDP_CLK_NS 50
`endif

// >>> rtl/ddp_pkg.sv
// Purpose: shared types for the memory pin datapath
// Assumes: nothing
// Notes: direction of the datapath
package ddp_pkg;
    typedef enum logic [1:0] {
        DDP_IDLE = 2'b00,
        DDP_READ = 2'b01,
        DDP_WRITE = 2'b11
    } ddp_mode_t;
endpackage : ddp_pkg

// >>> rtl/ddp_sync.sv
// Purpose: three-stage level synchroniser
// Assumes: async input
// Notes: change counts when stages two and three agree
`timescale 1ns/1ps
module ddp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    if (W < 1) begin : g_bad_w
        $error("width must be at least one");
    end
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ddp_sync_st_t;
    ddp_sync_st_t st_reg;
    ddp_sync_st_t st_next;
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.q = st_reg.s3;
        end
        if (!rst_n) begin
            st_next = '0;
        end
    end
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end
    assign q = st_reg.q;
endmodule : ddp_sync
